//--- verilog/emp_pkg.sv
// Shared constants, register map and state types of the external memory port
package emp_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 10000;
   localparam int INPUT_CLOCK_PERIOD_PS = 48830;
   localparam int AS_LOW_PS = 35000;
   localparam int AS_TO_DS_PS = 48000;
   localparam int DS_READ_PS = 125000;
   localparam int DS_WRITE_PS = 75000;
   localparam int TPC_CYC = (INPUT_CLOCK_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int AS_CYC = (AS_LOW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int ASDS_CYC = (AS_TO_DS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int DSR_CYC = (DS_READ_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int DSW_CYC = (DS_WRITE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int EXT_CYC = 2 * TPC_CYC;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_MODE = 4'h1;
   localparam logic [3:0] REG_P0DATA = 4'h2;
   localparam logic [3:0] REG_P0PIN = 4'h3;
   localparam logic [3:0] REG_ADDRL = 4'h4;
   localparam logic [3:0] REG_ADDRH = 4'h5;
   localparam logic [3:0] REG_WDATA = 4'h6;
   localparam logic [3:0] REG_CMD = 4'h7;
   localparam logic [3:0] REG_RDATA = 4'h8;
   localparam logic [3:0] REG_STATUS = 4'h9;
   localparam logic [3:0] REG_HSIN = 4'ha;

   localparam int CTRL_EXT_TIMING = 0;
   localparam int CTRL_BUS_FLOAT = 1;
   localparam int CTRL_HS_EN = 2;
   localparam int MODE_LO_ADDR = 0;
   localparam int MODE_HI_ADDR = 1;
   localparam int MODE_LO_OUT = 2;
   localparam int MODE_HI_OUT = 3;
   localparam int CMD_WRITE = 0;
   localparam int CMD_DATA_SPACE = 1;
   localparam int ST_BUSY = 0;
   localparam int ST_HS_FULL = 1;
   localparam int ST_HS_OUT_BUSY = 2;
   localparam int ST_ROM_OFF = 3;
   localparam int ST_HS_OVR = 4;

   localparam logic [15:0] ROM_TOP_DEFAULT = 16'h6000;

   // ------------------------------------------------------------
   // State types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      B_IDLE = 3'b000,
      B_AS = 3'b001,
      B_GAP = 3'b010,
      B_DS = 3'b011,
      B_END = 3'b100
   } emp_bus_e;

   typedef enum logic [1:0] {
      O_IDLE = 2'b00,
      O_SETUP = 2'b01,
      O_VALID = 2'b10,
      O_WAITHI = 2'b11
   } emp_hso_e;

   typedef enum logic {
      I_IDLE = 1'b0,
      I_WAIT = 1'b1
   } emp_hsi_e;

endpackage

//--- verilog/emp_ext_bus.sv
// External memory bus controller with high-address port and its byte handshake
module emp_ext_bus #(
   parameter logic [15:0] ROM_TOP = emp_pkg::ROM_TOP_DEFAULT
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic internal_rom_disable,
   output logic address_strobe_n,
   output logic data_strobe_n,
   output logic read_write,
   output logic bus_ctl_oe_n,
   output logic [7:0] hiport_out,
   output logic [7:0] hiport_oe_n,
   input wire logic [7:0] hiport_in,
   output logic [7:0] lowport_out,
   output logic [7:0] lowport_oe_n,
   input wire logic [7:0] lowport_in,
   input wire logic ctl_line_two,
   output logic ctl_line_five
);
   import emp_pkg::*;

   if (ROM_TOP == 16'h0000) begin : g_bad_rom_top
      $error("ROM_TOP must be nonzero");
   end

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic init_done_r;
   logic rom_off_r;
   logic ext_timing_r;
   logic bus_float_r;
   logic hs_en_r;
   logic lo_addr_r;
   logic hi_addr_r;
   logic lo_out_r;
   logic hi_out_r;
   logic [7:0] p0_data_r;
   logic [7:0] p0_keep_r;
   logic [15:0] addr_r;
   logic [7:0] wdata_r;
   logic [7:0] rdata_mem_r;
   logic [7:0] hs_in_data_r;
   logic hs_full_r;
   logic hs_ovr_r;
   emp_bus_e bst_r;
   logic [7:0] bcnt_r;
   logic op_wr_r;
   logic cyc_ext_r;
   logic cyc_long_r;
   emp_hso_e ost_r;
   logic [7:0] ocnt_r;
   logic out_valid_n_r;
   emp_hsi_e ist_r;
   logic in_ready_r;
   logic start;
   logic start_ext;
   logic hs_out_mode;
   logic hs_in_mode;
   logic hs_capture;
   logic hsin_read;
   logic lo_drive;
   logic hi_drive;
   logic [7:0] ds_cnt_nxt;

   assign start = reg_wr && (reg_addr == REG_CMD) && (bst_r == B_IDLE) && init_done_r;
   // Program space below ROM_TOP is internal unless the strap disabled the ROM
   assign start_ext = reg_wdata[CMD_DATA_SPACE] || rom_off_r || (addr_r >= ROM_TOP);
   assign hs_out_mode = hs_en_r && hi_out_r;
   assign hs_in_mode = hs_en_r && !hi_out_r;
   assign hsin_read = reg_rd && (reg_addr == REG_HSIN);
   assign hs_capture = hs_in_mode && (ist_r == I_IDLE) && !ctl_line_two;

   // ------------------------------------------------------------
   // Configuration and strap capture
   // ------------------------------------------------------------
   // The strap is caught on the first edge after release, never under reset
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         init_done_r <= 1'b0;
         rom_off_r <= 1'b0;
         ext_timing_r <= 1'b0;
         bus_float_r <= 1'b0;
         hs_en_r <= 1'b0;
         lo_addr_r <= 1'b0;
         hi_addr_r <= 1'b0;
         lo_out_r <= 1'b0;
         hi_out_r <= 1'b0;
      end else if (!init_done_r) begin
         init_done_r <= 1'b1;
         rom_off_r <= internal_rom_disable;
         ext_timing_r <= internal_rom_disable;
         lo_addr_r <= internal_rom_disable;
         hi_addr_r <= internal_rom_disable;
         lo_out_r <= 1'b0;
         hi_out_r <= 1'b0;
      end else if (reg_wr && (reg_addr == REG_CTRL)) begin
         ext_timing_r <= reg_wdata[CTRL_EXT_TIMING];
         bus_float_r <= reg_wdata[CTRL_BUS_FLOAT];
         hs_en_r <= reg_wdata[CTRL_HS_EN];
      end else if (reg_wr && (reg_addr == REG_MODE)) begin
         lo_addr_r <= reg_wdata[MODE_LO_ADDR];
         hi_addr_r <= reg_wdata[MODE_HI_ADDR];
         lo_out_r <= reg_wdata[MODE_LO_OUT];
         hi_out_r <= reg_wdata[MODE_HI_OUT];
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         addr_r <= 16'h0000;
         wdata_r <= 8'h00;
         p0_data_r <= 8'h00;
      end else if (reg_wr && init_done_r) begin
         if (reg_addr == REG_ADDRL && bst_r == B_IDLE) begin
            addr_r[7:0] <= reg_wdata;
         end
         if (reg_addr == REG_ADDRH && bst_r == B_IDLE) begin
            addr_r[15:8] <= reg_wdata;
         end
         if (reg_addr == REG_WDATA && bst_r == B_IDLE) begin
            wdata_r <= reg_wdata;
         end
         // Data may not change under a running output handshake
         if (reg_addr == REG_P0DATA && ost_r == O_IDLE) begin
            p0_data_r <= reg_wdata;
         end
      end
   end

   // Keeper: an undriven pin reads back whatever level it last settled at
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         p0_keep_r <= 8'h00;
      end else begin
         p0_keep_r <= hiport_in;
      end
   end

   // ------------------------------------------------------------
   // Machine cycle sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         bst_r <= B_IDLE;
         bcnt_r <= 8'h00;
         op_wr_r <= 1'b0;
         cyc_ext_r <= 1'b0;
         cyc_long_r <= 1'b0;
      end else begin
         unique case (bst_r)
            B_IDLE: begin
               if (start) begin
                  bst_r <= B_AS;
                  bcnt_r <= 8'(AS_CYC - 1);
                  op_wr_r <= reg_wdata[CMD_WRITE];
                  cyc_ext_r <= start_ext;
                  cyc_long_r <= ext_timing_r;
               end
            end
            B_AS: begin
               if (bcnt_r == 8'h00) begin
                  bst_r <= B_GAP;
                  bcnt_r <= 8'(ASDS_CYC - 1);
               end else begin
                  bcnt_r <= bcnt_r - 8'h01;
               end
            end
            B_GAP: begin
               if (bcnt_r == 8'h00) begin
                  bst_r <= B_DS;
                  bcnt_r <= ds_cnt_nxt;
               end else begin
                  bcnt_r <= bcnt_r - 8'h01;
               end
            end
            B_DS: begin
               if (bcnt_r == 8'h00) begin
                  bst_r <= B_END;
               end else begin
                  bcnt_r <= bcnt_r - 8'h01;
               end
            end
            B_END: begin
               // One idle cycle keeps the strobes apart across machine cycles
               bst_r <= B_IDLE;
            end
            default: begin
               bst_r <= B_IDLE;
            end
         endcase
      end
   end

   always_comb begin
      ds_cnt_nxt = op_wr_r ? 8'(DSW_CYC - 1) : 8'(DSR_CYC - 1);
      if (cyc_long_r) begin
         ds_cnt_nxt = ds_cnt_nxt + 8'(EXT_CYC);
      end
   end

   // Read data is taken on the edge at which the data strobe rises
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rdata_mem_r <= 8'h00;
      end else if (bst_r == B_DS && bcnt_r == 8'h00 && !op_wr_r && cyc_ext_r) begin
         rdata_mem_r <= lowport_in;
      end
   end

   // ------------------------------------------------------------
   // Bus pins
   // ------------------------------------------------------------
   assign address_strobe_n = !(bst_r == B_AS);
   assign data_strobe_n = !(bst_r == B_DS && cyc_ext_r);
   assign read_write = !(op_wr_r && cyc_ext_r && (bst_r != B_IDLE) && (bst_r != B_END));
   assign bus_ctl_oe_n = bus_float_r;

   always_comb begin
      lowport_out = addr_r[7:0];
      lowport_oe_n = 8'hff;
      if (bst_r == B_AS) begin
         lowport_oe_n = 8'h00;
      end else if (op_wr_r && cyc_ext_r && (bst_r == B_GAP || bst_r == B_DS)) begin
         lowport_out = wdata_r;
         lowport_oe_n = 8'h00;
      end
      if (bus_float_r) begin
         lowport_oe_n = 8'hff;
      end
   end

   assign lo_drive = lo_addr_r ? !bus_float_r : lo_out_r;
   assign hi_drive = hi_addr_r ? !bus_float_r : hi_out_r;
   assign hiport_out[3:0] = lo_addr_r ? addr_r[11:8] : p0_data_r[3:0];
   assign hiport_out[7:4] = hi_addr_r ? addr_r[15:12] : p0_data_r[7:4];
   assign hiport_oe_n = {{4{!hi_drive}}, {4{!lo_drive}}};

   // ------------------------------------------------------------
   // Byte handshake on the high-address port
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ost_r <= O_IDLE;
         ocnt_r <= 8'h00;
         out_valid_n_r <= 1'b1;
      end else begin
         unique case (ost_r)
            O_IDLE: begin
               if (hs_out_mode && reg_wr && reg_addr == REG_P0DATA && init_done_r) begin
                  ost_r <= O_SETUP;
                  ocnt_r <= 8'(TPC_CYC - 1);
               end
            end
            O_SETUP: begin
               if (ocnt_r == 8'h00) begin
                  ost_r <= O_VALID;
                  out_valid_n_r <= 1'b0;
               end else begin
                  ocnt_r <= ocnt_r - 8'h01;
               end
            end
            O_VALID: begin
               if (!ctl_line_two) begin
                  ost_r <= O_WAITHI;
                  out_valid_n_r <= 1'b1;
               end
            end
            O_WAITHI: begin
               if (ctl_line_two) begin
                  ost_r <= O_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ist_r <= I_IDLE;
         in_ready_r <= 1'b1;
         hs_in_data_r <= 8'h00;
      end else begin
         unique case (ist_r)
            I_IDLE: begin
               if (hs_capture) begin
                  ist_r <= I_WAIT;
                  in_ready_r <= 1'b0;
                  hs_in_data_r <= hiport_in;
               end
            end
            I_WAIT: begin
               if (ctl_line_two) begin
                  ist_r <= I_IDLE;
                  in_ready_r <= 1'b1;
               end
            end
         endcase
      end
   end

   // A new byte that lands while software reads the old one keeps the flag set
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         hs_full_r <= 1'b0;
         hs_ovr_r <= 1'b0;
      end else begin
         if (hs_capture) begin
            hs_full_r <= 1'b1;
         end else if (hsin_read) begin
            hs_full_r <= 1'b0;
         end
         if (hs_capture && hs_full_r && !hsin_read) begin
            hs_ovr_r <= 1'b1;
         end else if (hsin_read) begin
            hs_ovr_r <= 1'b0;
         end
      end
   end

   assign ctl_line_five = hs_en_r ? (hi_out_r ? out_valid_n_r : in_ready_r) : 1'b1;

   // ------------------------------------------------------------
   // Register read port
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            REG_CTRL: reg_rdata <= {5'h00, hs_en_r, bus_float_r, ext_timing_r};
            REG_MODE: reg_rdata <= {4'h0, hi_out_r, lo_out_r, hi_addr_r, lo_addr_r};
            REG_P0DATA: reg_rdata <= p0_data_r;
            REG_P0PIN: reg_rdata <= p0_keep_r;
            REG_ADDRL: reg_rdata <= addr_r[7:0];
            REG_ADDRH: reg_rdata <= addr_r[15:8];
            REG_WDATA: reg_rdata <= wdata_r;
            REG_CMD: reg_rdata <= {6'h00, 1'b0, op_wr_r};
            REG_RDATA: reg_rdata <= rdata_mem_r;
            REG_STATUS: reg_rdata <= {3'h0, hs_ovr_r, rom_off_r, (ost_r != O_IDLE), hs_full_r, (bst_r != B_IDLE)};
            REG_HSIN: reg_rdata <= hs_in_data_r;
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   logic [7:0] ds_low_cnt_r;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ds_low_cnt_r <= 8'h00;
      end else if (!data_strobe_n) begin
         ds_low_cnt_r <= ds_low_cnt_r + 8'h01;
      end else begin
         ds_low_cnt_r <= 8'h00;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   a_as_one_pulse: assert property ($fell(address_strobe_n) |-> !address_strobe_n [*4]
      ##1 address_strobe_n ##1 address_strobe_n [*4]) else $error("address strobe width or count wrong");
   a_addr_on_as: assert property (!address_strobe_n |-> lowport_out == addr_r[7:0]
      && lowport_oe_n == 8'h00 || bus_float_r) else $error("address missing during address strobe");
   a_rw_level: assert property (!data_strobe_n |-> read_write == !op_wr_r)
      else $error("read/write level wrong during data strobe");
   a_float_all: assert property (bus_float_r |-> bus_ctl_oe_n && lowport_oe_n == 8'hff
      && (!lo_addr_r || hiport_oe_n[3:0] == 4'hf)) else $error("bus not fully floated");
   a_ds_external: assert property ($fell(data_strobe_n) |-> cyc_ext_r && $past(address_strobe_n, 5))
      else $error("data strobe on internal cycle or too close to address strobe");
   a_wr_data_ready: assert property ($fell(data_strobe_n) && op_wr_r |-> lowport_out == wdata_r
      && $past(lowport_out) == wdata_r) else $error("write data late");
   a_ds_width: assert property ($rose(data_strobe_n) |-> ds_low_cnt_r ==
      (op_wr_r ? 8'(DSW_CYC) : 8'(DSR_CYC)) + (cyc_long_r ? 8'(EXT_CYC) : 8'h00))
      else $error("data strobe width wrong");
   a_no_overlap: assert property (!data_strobe_n |-> address_strobe_n ##1 address_strobe_n)
      else $error("strobes overlap");
   a_addr_high: assert property (lo_addr_r && hi_addr_r |-> hiport_out == addr_r[15:8])
      else $error("high address wrong on port");
   a_hs_setup: assert property ($fell(out_valid_n_r) |-> hiport_out == $past(hiport_out, 5))
      else $error("output data not stable before valid");
   a_hs_in_ready: assert property (hs_capture |=> !in_ready_r)
      else $error("ready not lowered after valid fell");
   a_hs_in_rise: assert property (ist_r == I_WAIT && ctl_line_two |=> in_ready_r)
      else $error("ready not raised after valid rose");
   a_hs_out_ack: assert property (ost_r == O_VALID && !ctl_line_two |=> out_valid_n_r)
      else $error("valid not raised after ready fell");
   a_strap_reset: assert property ($rose(init_done_r) |-> lo_addr_r == internal_rom_disable
      && hi_addr_r == internal_rom_disable && ext_timing_r == internal_rom_disable)
      else $error("strap configuration wrong");

   c_ext_read: cover property ($rose(data_strobe_n) && !op_wr_r);
   c_ext_write_long: cover property ($rose(data_strobe_n) && op_wr_r && cyc_long_r);
   c_hs_out_done: cover property (ost_r == O_WAITHI && ctl_line_two);
   c_hs_in_byte: cover property (hs_capture);

endmodule // emp_ext_bus

//--- testbench/emp_mem_model.sv
// Partner model: external memory on the multiplexed address/data bus
module emp_mem_model (
   input wire logic clk_sys,
   input wire logic address_strobe_n,
   input wire logic data_strobe_n,
   input wire logic read_write,
   input wire logic [7:0] hiport_out,
   input wire logic [7:0] lowport_out,
   input wire logic [7:0] lowport_oe_n,
   output logic [7:0] low_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem_r [0:65535];
   logic [15:0] addr_r = 16'h0000;
   logic [7:0] last_r = 8'h00;
   logic [7:0] src;
   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem_r[i] = 8'(i[7:0] ^ i[15:8] ^ 8'h5a);
      end
   end
   // Pin level is sampled on every clock edge, whatever the strobes, to drive the released bus
   always @(posedge clk_sys) begin
      if (!address_strobe_n) addr_r <= {hiport_out, lowport_out};
      if (!data_strobe_n && !read_write) mem_r[addr_r] <= lowport_out;
      last_r <= low_pin;
   end
   // Released bus outside a read data strobe shows a changing level, never the last value
   assign src = (!data_strobe_n && read_write) ? mem_r[addr_r] : ~last_r;
   assign low_pin = (lowport_out & ~lowport_oe_n) | (src & lowport_oe_n);
endmodule // emp_mem_model

//--- testbench/tb.sv
// Self-checking bench for the external memory port
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import emp_pkg::*;
   logic clk_sys = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, strap = 1'b1, hs_two = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, hi_drv = 8'h00, reg_rdata, hiport_out, hiport_oe_n, lowport_out;
   logic [7:0] lowport_oe_n, low_pin, hp_last, exp_wd;
   logic address_strobe_n, data_strobe_n, read_write, bus_ctl_oe_n, ctl_line_five;
   logic as_l, ds_l, is_wr, chk_a;
   logic [15:0] cur_a;
   int bad_count = 0, total_checks = 0, as_cnt, as_fall, ds_cnt, ds_fall, bus_err, stab;
   wire logic [7:0] hi_pin = (hiport_out & ~hiport_oe_n) | (hi_drv & hiport_oe_n);
   always #5 clk_sys = ~clk_sys;
   emp_ext_bus dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .internal_rom_disable(strap),
      .address_strobe_n(address_strobe_n), .data_strobe_n(data_strobe_n), .read_write(read_write),
      .bus_ctl_oe_n(bus_ctl_oe_n), .hiport_out(hiport_out), .hiport_oe_n(hiport_oe_n), .hiport_in(hi_pin),
      .lowport_out(lowport_out), .lowport_oe_n(lowport_oe_n), .lowport_in(low_pin),
      .ctl_line_two(hs_two), .ctl_line_five(ctl_line_five));
   emp_mem_model mem_u (.clk_sys(clk_sys), .address_strobe_n(address_strobe_n),
      .data_strobe_n(data_strobe_n), .read_write(read_write), .hiport_out(hiport_out),
      .lowport_out(lowport_out), .lowport_oe_n(lowport_oe_n), .low_pin(low_pin));
   // --------------------------------------------
   // Bus phase monitor
   // --------------------------------------------
   always @(posedge clk_sys) begin
      as_l <= address_strobe_n;
      ds_l <= data_strobe_n;
      hp_last <= hiport_out;
      stab <= (hiport_out !== hp_last) ? 0 : stab + 1;
      // Counts restart as each command is taken, so one process alone owns them
      if (reg_wr && reg_addr == REG_CMD) begin
         as_cnt <= 0;
         as_fall <= 0;
         ds_cnt <= 0;
         ds_fall <= 0;
         bus_err <= 0;
      end else begin
         if (!address_strobe_n) as_cnt <= as_cnt + 1;
         if (!address_strobe_n && as_l) as_fall <= as_fall + 1;
         if (!data_strobe_n) ds_cnt <= ds_cnt + 1;
         if (!data_strobe_n && ds_l) ds_fall <= ds_fall + 1;
         if ((!data_strobe_n && read_write !== !is_wr) || (!address_strobe_n && !data_strobe_n)
            || (chk_a && !address_strobe_n && ({hiport_out, lowport_out} !== cur_a || lowport_oe_n !== 8'h00))
            || (!data_strobe_n && ds_l && is_wr && (lowport_out !== exp_wd || lowport_oe_n !== 8'h00)))
            bus_err <= bus_err + 1;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rchk(input logic [3:0] a, input logic [7:0] msk, input logic [7:0] exp, input string m);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata & msk, exp, m);
   endtask
   task automatic reset_dut(input logic s);
      @(posedge clk_sys);
      reset_n <= 1'b0;
      strap <= s;
      repeat (16) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
   endtask
   function automatic int ds_exp(input logic w, input logic x);
      return (w ? DSW_CYC : DSR_CYC) + (x ? EXT_CYC : 0);
   endfunction
   task automatic wait_five(input logic v, input int lim, input string m);
      int n;
      n = 0;
      while (ctl_line_five !== v && n < lim) begin
         @(posedge clk_sys);
         #1 n++;
      end
      chk(ctl_line_five, v, m);
      if (ctl_line_five !== v) give_verdict();
   endtask
   task automatic bus_op(input logic [15:0] a, input logic [7:0] d, input logic [1:0] c, input logic ck);
      cur_a = a;
      exp_wd = d;
      is_wr = c[0];
      chk_a = ck;
      wr(REG_ADDRL, a[7:0]);
      wr(REG_ADDRH, a[15:8]);
      wr(REG_WDATA, d);
      wr(REG_CMD, {6'h00, c});
      repeat (40) @(posedge clk_sys);
      chk(as_fall, 1, "as pulses");
      chk(as_cnt, AS_CYC, "as width");
      chk(ds_fall, {31'h0, ck}, "ds pulses");
      chk(bus_err, 0, "bus phase");
      rchk(REG_STATUS, 8'h01, 8'h00, "busy");
   endtask
   initial begin
      #900us bad_count++;
      give_verdict();
   end
   initial begin
      logic [7:0] d;
      chk_a = 1'b0;
      is_wr = 1'b0;
      void'($urandom(32'h8f48));
      reset_dut(1'b1);
      rchk(REG_MODE, 8'h03, 8'h03, "mode");
      rchk(REG_CTRL, 8'h01, 8'h01, "ext timing");
      rchk(REG_STATUS, 8'h08, 8'h08, "rom off");
      for (int k = 0; k < 4; k++) begin
         if (k == 2) wr(REG_CTRL, 8'h00);
         cur_a = 16'(16'h8000 | $urandom);
         d = 8'($urandom);
         bus_op(cur_a, d, 2'b11, 1'b1);
         chk(ds_cnt, ds_exp(1'b1, k < 2), "write ds width");
         bus_op(cur_a, 8'h00, 2'b10, 1'b1);
         chk(ds_cnt, ds_exp(1'b0, k < 2), "read ds width");
         rchk(REG_RDATA, 8'hff, d, "read back");
      end
      bus_op(16'hff00, 8'h00, 2'b10, 1'b1);
      rchk(REG_RDATA, 8'hff, 8'hff ^ 8'h5a, "fresh read");
      $display("memory cycles done");
      wr(REG_CTRL, 8'h02);
      @(posedge clk_sys);
      #1 chk({bus_ctl_oe_n, hiport_oe_n, lowport_oe_n}, {1'b1, 16'hffff}, "float");
      wr(REG_CTRL, 8'h04);
      wr(REG_MODE, 8'h0c);
      d = 8'($urandom);
      wr(REG_P0DATA, d);
      wait_five(1'b0, 20, "valid fall");
      chk(stab >= TPC_CYC - 1, 1, "data lead");
      chk({hiport_out, hiport_oe_n}, {d, 8'h00}, "out data");
      @(posedge clk_sys) hs_two <= 1'b0;
      wait_five(1'b1, 3, "valid rise");
      @(posedge clk_sys) hs_two <= 1'b1;
      rchk(REG_STATUS, 8'h04, 8'h00, "out done");
      wr(REG_MODE, 8'h00);
      d = 8'($urandom);
      hi_drv <= d;
      hs_two <= 1'b0;
      wait_five(1'b0, 4, "ready fall");
      chk(hiport_oe_n, 8'hff, "in dir");
      @(posedge clk_sys) hs_two <= 1'b1;
      wait_five(1'b1, 4, "ready rise");
      rchk(REG_STATUS, 8'h12, 8'h02, "in full");
      rchk(REG_HSIN, 8'hff, d, "in byte");
      rchk(REG_P0PIN, 8'hff, d, "pin level");
      $display("handshake done");
      wr(REG_CTRL, 8'h00);
      wr(REG_MODE, 8'h09);
      wr(REG_P0DATA, d);
      @(posedge clk_sys);
      #1 chk({hiport_oe_n[7:4], hiport_out[7:4]}, {4'h0, d[7:4]}, "upper io");
      rchk(4'hf, 8'hff, 8'h00, "unmapped");
      reset_dut(1'b0);
      rchk(REG_MODE, 8'h0f, 8'h00, "rom mode");
      chk(hiport_oe_n, 8'hff, "port input");
      rchk(REG_STATUS, 8'h08, 8'h00, "rom on");
      bus_op(16'h0100, 8'h00, 2'b00, 1'b0);
      wr(REG_MODE, 8'h03);
      bus_op(16'h0200, 8'h00, 2'b10, 1'b1);
      rchk(REG_RDATA, 8'hff, 8'h02 ^ 8'h5a, "data space");
      bus_op(16'h7000, 8'h00, 2'b00, 1'b1);
      chk(ds_cnt, ds_exp(1'b0, 1'b0), "plain ds width");
      rchk(REG_RDATA, 8'hff, 8'h70 ^ 8'h5a, "ext fetch");
      $display("rom mode done");
      give_verdict();
   end
endmodule // tb
